// ===== rtl/djtc_consts.svh
// register offsets, field positions and timing constants of the attenuator config bank
`ifndef DJTC_CONSTS_SVH
`define DJTC_CONSTS_SVH
`define DJTC_NUM_CH 3
`define DJTC_IDX_CHCTL0 8'h06
`define DJTC_IDX_JACTL0 8'h07
`define DJTC_IDX_CHCTL1 8'h0e
`define DJTC_IDX_JACTL1 8'h0f
`define DJTC_IDX_CHCTL2 8'h16
`define DJTC_IDX_JACTL2 8'h17
`define DJTC_CH_STRIDE 8'h08
`define DJTC_CH_MASK 8'h3f
`define DJTC_JA_MASK 8'h1f
`define DJTC_RESET_VAL 8'h00
`define DJTC_BIT_RAIL 0
`define DJTC_BIT_R51 1
`define DJTC_BIT_R34 2
`define DJTC_BIT_LLB 3
`define DJTC_BIT_RLB 4
`define DJTC_BIT_PRBS 5
`define DJTC_BIT_BWL 0
`define DJTC_BIT_PATH 1
`define DJTC_BIT_BWH 2
`define DJTC_BIT_JARST 3
`define DJTC_BIT_FRD 4
`define DJTC_MAX_GAP_BITS 7'd59
`define DJTC_FIFO_DEPTH 128
`endif

// ===== rtl/djtc_pkg.sv
// types of the attenuator config bank
package djtc_pkg;
  typedef struct packed {
    logic pseudo_random_test_enable;
    logic remote_loopback_enable;
    logic local_loopback_enable;
    logic rate_34m_select;
    logic rate_51m_vs_44m_select;
    logic rail_select;
  } djtc_chctl_s;
  typedef struct packed {
    logic fast_recovery_disable;
    logic attenuator_reset;
    logic bandwidth_select_high;
    logic attenuator_path_select;
    logic bandwidth_select_low;
  } djtc_jactl_s;
  typedef struct packed {
    logic single_rail;
    logic desync_narrow_bw;
    logic path_tx;
    logic fast_recovery;
    logic atten_reset;
    logic [1:0] bw_code;
  } djtc_chcfg_s;
  typedef struct packed {
    logic pin_mode;
    logic rail_select;
    logic bandwidth_select_low;
    logic bandwidth_select_high;
    logic attenuator_path_select;
  } djtc_strap_s;
endpackage

// ===== rtl/djtc_top.sv
// apb register bank and per-channel gapped-clock capture for the de-sync attenuator
//
// Overview of operation
// - rail select bit 0 or strap high selects single-rail data and clock
// - register mode: bit 0 set and bit 2 clear selects de-sync setting
// - pin mode: low strap high, high strap low selects de-sync setting
// - path bit 1 or strap high puts attenuator in transmit path
// - recovery disable bit 4 clear runs fast recovery mode
// - fast recovery disable honoured only in register mode
// - channel control fields bits 5..0; bits 7,6 read zero
// - attenuator control fields bits 4..0; bits 7..5 read zero
// - capture tolerates 59 clockless clk_sys cycles then flags overrun
// - clock edge only on payload bits; device samples data on it
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "djtc_consts.svh"
module djtc_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire djtc_pkg::djtc_strap_s strap,
  input wire logic [2:0] tx_line_clock,
  input wire logic [2:0] tx_line_data,
  output djtc_pkg::djtc_chcfg_s [2:0] ch_cfg,
  output logic [2:0] tx_bit_valid,
  output logic [2:0] tx_bit_data,
  output logic [2:0] gap_overrun
);
  typedef struct packed {
    djtc_pkg::djtc_chctl_s [2:0] chctl;
    djtc_pkg::djtc_jactl_s [2:0] jactl;
    djtc_pkg::djtc_strap_s strap_m;
    djtc_pkg::djtc_strap_s strap_s;
    djtc_pkg::djtc_chcfg_s [2:0] cfg;
    logic [31:0] rdata;
    logic [2:0] tgl_m;
    logic [2:0] tgl_s;
    logic [2:0] tgl_d;
    logic [2:0] vld;
    logic [2:0] dat;
    logic [2:0][6:0] gap_cnt;
    logic [2:0] overrun;
  } djtc_state_s;

  djtc_state_s st_reg;
  djtc_state_s st_next;

  // link side: a toggle flop and a two-entry data pair per channel on its own gapped clock
  logic [2:0] lk_tgl_reg;
  logic [2:0][1:0] lk_dat_reg;

  function automatic logic [2:0] djtc_decode(input logic [7:0] idx, output logic is_ja);
    is_ja = idx[0];
    case (idx)
      `DJTC_IDX_CHCTL0, `DJTC_IDX_JACTL0: djtc_decode = 3'b001;
      `DJTC_IDX_CHCTL1, `DJTC_IDX_JACTL1: djtc_decode = 3'b010;
      `DJTC_IDX_CHCTL2, `DJTC_IDX_JACTL2: djtc_decode = 3'b100;
      default: djtc_decode = 3'b000;
    endcase
  endfunction

  // de-sync setting: low select set, high select clear
  function automatic logic djtc_narrow_bw(input logic bw_low, input logic bw_high);
    djtc_narrow_bw = bw_low && !bw_high;
  endfunction

  // data sampled on the mapper's gapped clock; toggle marks each payload bit
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_link
      // toggle starts known: a gapped clock cannot be reset
      logic tgl_bit_reg = 1'b0;
      logic [1:0] dat_pair_reg;
      always_ff @(posedge tx_line_clock[g])
      begin
        tgl_bit_reg <= ~tgl_bit_reg;
        // two entries: a bit stands two slots, so 51.84 MHz bursts survive the crossing
        dat_pair_reg[~tgl_bit_reg] <= tx_line_data[g];
      end
      assign lk_tgl_reg[g] = tgl_bit_reg;
      assign lk_dat_reg[g] = dat_pair_reg;
    end
  endgenerate

  logic access;
  logic [2:0] sel;
  logic sel_ja;
  logic [7:0] idx;

  always_comb
  begin
    st_next = st_reg;
    idx = paddr[9:2];
    sel = djtc_decode(idx, sel_ja);
    access = psel && penable;
    // straps are pins: two flops before use
    st_next.strap_m = strap;
    st_next.strap_s = st_reg.strap_m;
    // crossing of the bit toggle; data stays stable while toggle resolves
    st_next.tgl_m = lk_tgl_reg;
    st_next.tgl_s = st_reg.tgl_m;
    st_next.tgl_d = st_reg.tgl_s;
    st_next.vld = st_reg.tgl_s ^ st_reg.tgl_d;
    for (int c = 0; c < 3; c++)
    begin
      if (st_reg.tgl_s[c] ^ st_reg.tgl_d[c])
        st_next.dat[c] = lk_dat_reg[c][st_reg.tgl_s[c]];
    end
    if (access && pwrite)
    begin
      for (int c = 0; c < 3; c++)
      begin
        if (sel[c] && sel_ja)
          st_next.jactl[c] = 5'(pwdata[7:0] & `DJTC_JA_MASK);
        else if (sel[c])
          st_next.chctl[c] = 6'(pwdata[7:0] & `DJTC_CH_MASK);
      end
    end
    st_next.rdata = 32'h0000_0000;
    for (int c = 0; c < 3; c++)
    begin
      if (sel[c] && sel_ja)
        st_next.rdata = {27'h0, st_reg.jactl[c]};
      else if (sel[c])
        st_next.rdata = {26'h0, st_reg.chctl[c]};
    end
    for (int c = 0; c < 3; c++)
    begin
      // config registered after the control register: takes effect two cycles after the write
      if (st_reg.strap_s.pin_mode)
      begin
        st_next.cfg[c].single_rail = st_reg.strap_s.rail_select;
        st_next.cfg[c].bw_code = {st_reg.strap_s.bandwidth_select_high, st_reg.strap_s.bandwidth_select_low};
        st_next.cfg[c].desync_narrow_bw = djtc_narrow_bw(st_reg.strap_s.bandwidth_select_low,
          st_reg.strap_s.bandwidth_select_high);
        st_next.cfg[c].path_tx = st_reg.strap_s.attenuator_path_select;
        st_next.cfg[c].fast_recovery = 1'b1;
        st_next.cfg[c].atten_reset = 1'b0;
      end
      else
      begin
        st_next.cfg[c].single_rail = st_reg.chctl[c].rail_select;
        st_next.cfg[c].bw_code = {st_reg.jactl[c].bandwidth_select_high, st_reg.jactl[c].bandwidth_select_low};
        st_next.cfg[c].desync_narrow_bw = djtc_narrow_bw(st_reg.jactl[c].bandwidth_select_low,
          st_reg.jactl[c].bandwidth_select_high);
        st_next.cfg[c].path_tx = st_reg.jactl[c].attenuator_path_select;
        st_next.cfg[c].fast_recovery = !st_reg.jactl[c].fast_recovery_disable;
        st_next.cfg[c].atten_reset = st_reg.jactl[c].attenuator_reset;
      end
      // gap watch: sticky flag when more than 59 clk_sys cycles pass without a valid bit
      if (st_reg.cfg[c].atten_reset)
      begin
        st_next.gap_cnt[c] = 7'd0;
        st_next.overrun[c] = 1'b0;
      end
      else if (st_reg.vld[c])
        st_next.gap_cnt[c] = 7'd0;
      else if (st_reg.gap_cnt[c] != 7'h7f)
        st_next.gap_cnt[c] = st_reg.gap_cnt[c] + 7'd1;
      // set wins over the clear; a held attenuator reset clears it a cycle later
      if (st_reg.gap_cnt[c] > `DJTC_MAX_GAP_BITS)
        st_next.overrun[c] = 1'b1;
    end
    if (rst)
    begin
      st_next.chctl = '0;
      st_next.jactl = '0;
      st_next.cfg = '0;
      st_next.rdata = 32'h0000_0000;
      st_next.vld = 3'b000;
      st_next.dat = 3'b000;
      st_next.gap_cnt = '0;
      st_next.overrun = 3'b000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    st_reg <= st_next;
  end

  // read data registered in setup; answer comes in first access cycle
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access && (sel == 3'b000);
  assign ch_cfg = st_reg.cfg;
  assign tx_bit_valid = st_reg.vld & ~{st_reg.cfg[2].atten_reset, st_reg.cfg[1].atten_reset, st_reg.cfg[0].atten_reset};
  assign tx_bit_data = st_reg.dat;
  assign gap_overrun = st_reg.overrun;
endmodule

// ===== verification/djtc_chk.sv
// checker on the attenuator config bank ports
`timescale 1ns/100ps
module djtc_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire djtc_pkg::djtc_strap_s strap,
  input wire djtc_pkg::djtc_chcfg_s [2:0] ch_cfg,
  input wire logic [2:0] tx_bit_valid,
  input wire logic [2:0] gap_overrun
);
  wire acc = psel && penable;
  wire [7:0] idx = paddr[9:2];
  wire pm = strap.pin_mode;
  wire w6 = acc && pwrite && idx == 8'h06 && !pm;
  wire w7 = acc && pwrite && idx == 8'h07 && !pm;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_rail; w6 |-> ##2 ch_cfg[0].single_rail == $past(pwdata[0], 2); endproperty
  a_rail: assert property (p_rail) else $error("rail");
  property p_bw; w7 |-> ##2 ch_cfg[0].desync_narrow_bw == ($past(pwdata[0], 2) && !$past(pwdata[2], 2)); endproperty
  a_bw: assert property (p_bw) else $error("bw");
  property p_path; w7 |-> ##2 ch_cfg[0].path_tx == $past(pwdata[1], 2); endproperty
  a_path: assert property (p_path) else $error("path");
  property p_fast; w7 |-> ##2 ch_cfg[0].fast_recovery != $past(pwdata[4], 2); endproperty
  a_fast: assert property (p_fast) else $error("fast");
  property p_pinfr; pm [*5] |-> ch_cfg[0].fast_recovery; endproperty
  a_pinfr: assert property (p_pinfr) else $error("pin fast");
  property p_pinbw; (pm && strap.bandwidth_select_low && !strap.bandwidth_select_high) [*5] |-> ch_cfg[0].desync_narrow_bw; endproperty
  a_pinbw: assert property (p_pinbw) else $error("pin bw");
  property p_err; acc |-> pslverr == !(idx inside {8'h06, 8'h07, 8'h0e, 8'h0f, 8'h16, 8'h17}); endproperty
  a_err: assert property (p_err) else $error("err");
  property p_jarst; ch_cfg[0].atten_reset [*3] |-> !tx_bit_valid[0]; endproperty
  a_jarst: assert property (p_jarst) else $error("jarst");
  property p_jaovr; ch_cfg[0].atten_reset [*3] |-> !gap_overrun[0]; endproperty
  a_jaovr: assert property (p_jaovr) else $error("overrun not cleared by attenuator reset");
  property p_rst; $fell(rst) |-> ch_cfg == '0 && gap_overrun == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("config not zero after reset");
endmodule
bind djtc_top djtc_chk i_djtc_chk (.*);

// ===== verification/djtc_mapper_model.sv
// mapper model: gapped link clock and data
`timescale 1ns/100ps
module djtc_mapper_model (
  input wire logic go,
  output logic [2:0] tx_line_clock,
  output logic [2:0] tx_line_data
);
  int sent = 0;
  // one slot per 51.84 MHz period: data set while low, pulse only for a payload bit
  task automatic slot(input logic p);
    tx_line_data = p ? {3{sent[0] ^ sent[2]}} : ~tx_line_data;
    #9.7;
    tx_line_clock = {3{p}};
    #9.6;
    tx_line_clock = 3'h0;
    sent += p;
  endtask
  task automatic minor(input int n, input logic gap);
    repeat (n) slot(1'b1);
    if (gap) slot(1'b0);
  endtask
  task automatic major(input int n5, input logic tail);
    repeat (63) minor(7, 1'b1);
    repeat (n5) minor(5, 1'b1);
    if (tail) minor(6, 1'b0);
  endtask
  initial
  begin
    tx_line_clock = 3'h0;
    tx_line_data = 3'h0;
    forever
    begin
      wait (go);
      major(36, 1'b0);
      major(36, 1'b0);
      major(35, 1'b1);
    end
  end
endmodule

// ===== verification/tb_desync_jitter_tx_config.sv
// bench for the attenuator config bank
`timescale 1ns/100ps
module tb_desync_jitter_tx_config;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, go, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [2:0] tx_line_clock, tx_line_data, tx_bit_valid, tx_bit_data, gap_overrun;
  djtc_pkg::djtc_strap_s strap;
  djtc_pkg::djtc_chcfg_s [2:0] ch_cfg;
  int checks = 0;
  int n_mismatch = 0;
  int nbit = 0;
  djtc_top i_djtc_top (.*);
  djtc_mapper_model i_djtc_mapper_model (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk_sys) penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input int c, input logic [3:0] e);
    repeat (2) @(negedge clk_sys);
    chk("cfg", {ch_cfg[c].single_rail, ch_cfg[c].desync_narrow_bw, ch_cfg[c].path_tx, ch_cfg[c].fast_recovery}, e);
  endtask
  task automatic t_regs;
    logic [7:0] a;
    for (int i = 0; i < 6; i++)
    begin
      a = 8'h06 + 8'((i / 2) * 8 + i % 2);
      apb(1'b0, a, 8'h00);
      chk("reset", rd, 32'h0);
      apb(1'b1, a, 8'hff);
      apb(1'b0, a, 8'h00);
      chk("mask", rd, i % 2 ? 32'h1f : 32'h3f);
      if (i % 2 == 0) continue;
      apb(1'b1, a - 8'h01, 8'h01);
      apb(1'b1, a, 8'h13);
      cfg(i / 2, 4'he);
      chk("bw code", ch_cfg[i / 2].bw_code, 32'h1);
      apb(1'b1, a, 8'h05);
      cfg(i / 2, 4'h9);
      chk("bw code", ch_cfg[i / 2].bw_code, 32'h3);
    end
    apb(1'b1, 8'h05, 8'hff);
    chk("err", err, 32'h1);
    apb(1'b0, 8'h05, 8'h00);
    chk("unmapped", rd, 32'h0);
  endtask
  // reset first clears any stale overrun
  task automatic t_stream(input logic [7:0] ja, input int n);
    apb(1'b1, 8'h07, 8'h08);
    apb(1'b1, 8'h07, ja);
    repeat (2) @(negedge clk_sys);
    chk("ja reset", ch_cfg[0].atten_reset, ja[3]);
    @(posedge clk_sys) go <= 1'b1;
    @(posedge clk_sys) go <= 1'b0;
    wait (i_djtc_mapper_model.sent == n);
    repeat (45) @(negedge clk_sys);
    chk("bits", nbit, 1864);
    chk("gap", gap_overrun[0], 32'h0);
    repeat (35) @(negedge clk_sys);
    chk("gap late", gap_overrun[0], ja == 8'h00);
  endtask
  task automatic t_pin;
    @(posedge clk_sys) strap <= 5'h1d;
    apb(1'b1, 8'h07, 8'h10);
    for (int c = 0; c < 3; c++) cfg(c, 4'hf);
  endtask
  always @(negedge clk_sys)
    if (tx_bit_valid[0] === 1'b1)
    begin
      chk("data", tx_bit_data[0], nbit[0] ^ nbit[2]);
      nbit++;
    end
  task automatic test_done;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, go} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    strap = 5'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_stream(8'h00, 1864);
    t_stream(8'h08, 3728);
    t_pin();
    test_done();
  end
endmodule
